// ### logic/instr_exec_core.sv
// execution core with axi4-lite register access
`timescale 1ns/10ps
module instr_exec_core #(
  parameter int unsigned FILE_DEPTH = 128,
  parameter int unsigned PRE_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output logic core_sleeping
);

  localparam int unsigned FA_W = $clog2(FILE_DEPTH);

  initial begin
    if (FILE_DEPTH < 2 || FILE_DEPTH > 128 ||
        (FILE_DEPTH & (FILE_DEPTH - 1)) != 0) begin
      $error("FILE_DEPTH must be a power of two from 2 to 128");
    end
    if (PRE_W < 1 || PRE_W > 16) begin
      $error("PRE_W must lie between 1 and 16");
    end
  end

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      exec_pkg::OFS_INSTR, exec_pkg::OFS_WREG, exec_pkg::OFS_STATUS,
      exec_pkg::OFS_DIR_A, exec_pkg::OFS_DIR_B, exec_pkg::OFS_DIR_C,
      exec_pkg::OFS_WDT, exec_pkg::OFS_FILE_ADDR,
      exec_pkg::OFS_FILE_DATA: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction

  // architectural, bus and decode state
  logic [7:0] w_r, dir_a_r, dir_b_r, dir_c_r, watchdog_counter_r;
  logic c_r, dc_r, z_r, powerdown_status_bit_r, timeout_status_bit_r, sleep_r;
  logic [PRE_W-1:0] wdt_pre_r;
  logic [FA_W-1:0] file_addr_r;
  logic [7:0] file_mem [FILE_DEPTH];
  logic aw_held_r, w_held_r, awready_r, wready_r, bvalid_r;
  logic arready_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire, lane0, ins_dest, ins_dest_given, ins_write, ins_refused;
  logic exec_go, to_file, alu_writes, alu_c, alu_dc, alu_z, sw_wr_w;
  logic alu_upd_cdc, alu_upd_z, sw_wr_status, sw_wr_faddr, sw_wr_fdata;
  exec_pkg::op_t ins_op;
  logic [7:0] ins_arg, f_val, alu_res;
  logic [FA_W-1:0] f_idx;

  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign lane0 = wstrb_r[0];
  assign ins_op = exec_pkg::op_t'(wdata_r[exec_pkg::INS_OP_LSB +: 4]);
  assign ins_arg = wdata_r[exec_pkg::INS_ARG_LSB +: 8];
  assign ins_dest = wdata_r[exec_pkg::INS_DEST_BIT];
  assign ins_dest_given = wdata_r[exec_pkg::INS_DEST_GIVEN_BIT];
  assign f_idx = ins_arg[FA_W-1:0];
  assign f_val = file_mem[f_idx];
  assign ins_write = wr_fire && lane0 && (awaddr_r == exec_pkg::OFS_INSTR);
  // a halted core takes no instructions until software wakes it
  assign ins_refused = ins_write && sleep_r;
  assign exec_go = ins_write && !sleep_r;
  assign sw_wr_w = wr_fire && lane0 && (awaddr_r == exec_pkg::OFS_WREG);
  assign sw_wr_status = wr_fire && lane0 &&
                        (awaddr_r == exec_pkg::OFS_STATUS);
  assign sw_wr_faddr = wr_fire && lane0 &&
                       (awaddr_r == exec_pkg::OFS_FILE_ADDR);
  assign sw_wr_fdata = wr_fire && lane0 &&
                       (awaddr_r == exec_pkg::OFS_FILE_DATA);

  exec_alu u_alu (
    .op(ins_op),
    .w_val(w_r),
    .f_val(f_val),
    .k_val(ins_arg),
    .c_in(c_r),
    .result(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z),
    .upd_cdc(alu_upd_cdc),
    .upd_z(alu_upd_z)
  );

  // destination choice per instruction
  always_comb begin
    alu_writes = 1'b0;
    to_file = 1'b0;
    case (ins_op)
      exec_pkg::OP_SUB_LIT, exec_pkg::OP_XOR_LIT: begin
        alu_writes = 1'b1;
        to_file = 1'b0; // RL3 RL11
      end
      exec_pkg::OP_SUB_FILE, exec_pkg::OP_SUB_BORROW,
      exec_pkg::OP_XOR_FILE: begin
        alu_writes = 1'b1;
        to_file = ins_dest; // RL6 RL7 RL12
      end
      exec_pkg::OP_SWAP: begin
        alu_writes = 1'b1;
        to_file = ins_dest_given ? ins_dest : 1'b1; // RL9
      end
      default: ;
    endcase
  end

  // axi write address and data, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && awready_r) begin
      aw_held_r <= 1'b1;
      awready_r <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && wready_r) begin
      w_held_r <= 1'b1;
      wready_r <= 1'b0;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= exec_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= (!is_mapped(awaddr_r) || ins_refused) ?
                 exec_pkg::RESP_SLVERR : exec_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // axi read channel
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      exec_pkg::OFS_WREG: begin
        rd_val[7:0] = w_r;
      end
      exec_pkg::OFS_STATUS: begin
        rd_val[exec_pkg::ST_C] = c_r;
        rd_val[exec_pkg::ST_DC] = dc_r;
        rd_val[exec_pkg::ST_Z] = z_r;
        rd_val[exec_pkg::ST_PD] = powerdown_status_bit_r;
        rd_val[exec_pkg::ST_TO] = timeout_status_bit_r;
        rd_val[exec_pkg::ST_SLEEP] = sleep_r;
      end
      exec_pkg::OFS_DIR_A: begin
        rd_val[7:0] = dir_a_r;
      end
      exec_pkg::OFS_DIR_B: begin
        rd_val[7:0] = dir_b_r;
      end
      exec_pkg::OFS_DIR_C: begin
        rd_val[7:0] = dir_c_r;
      end
      exec_pkg::OFS_WDT: begin
        rd_val[7:0] = watchdog_counter_r;
        rd_val[8 +: PRE_W] = wdt_pre_r;
      end
      exec_pkg::OFS_FILE_ADDR: begin
        rd_val[FA_W-1:0] = file_addr_r;
      end
      exec_pkg::OFS_FILE_DATA: begin
        rd_val[7:0] = file_mem[file_addr_r];
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= exec_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= is_mapped(s_axi_araddr) ?
                 exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // working register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_r <= 8'h00;
    end else if (exec_go && alu_writes && !to_file) begin
      w_r <= alu_res; // RL6
    end else if (sw_wr_w) begin
      w_r <= wdata_r[7:0];
    end
  end

  // arithmetic flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_r <= 1'b0;
      dc_r <= 1'b0;
      z_r <= 1'b0;
    end else if (exec_go) begin
      if (alu_upd_cdc) begin
        c_r <= alu_c; // RL4 RL5 RL7
        dc_r <= alu_dc; // RL4
      end
      if (alu_upd_z) begin
        z_r <= alu_z; // RL13
      end
    end else if (sw_wr_status) begin
      c_r <= wdata_r[exec_pkg::ST_C];
      dc_r <= wdata_r[exec_pkg::ST_DC];
      z_r <= wdata_r[exec_pkg::ST_Z];
    end
  end

  // power status and halt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powerdown_status_bit_r <= 1'b1;
      timeout_status_bit_r <= 1'b1;
      sleep_r <= 1'b0;
    end else if (exec_go && ins_op == exec_pkg::OP_SLEEP) begin
      powerdown_status_bit_r <= 1'b0; // RL1
      timeout_status_bit_r <= 1'b1; // RL1
      sleep_r <= 1'b1;
    end else if (sw_wr_status && !wdata_r[exec_pkg::ST_SLEEP]) begin
      sleep_r <= 1'b0;
    end
  end

  // watchdog counter and prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_counter_r <= exec_pkg::WDT_CLEAR;
      wdt_pre_r <= '0;
    end else if (exec_go && ins_op == exec_pkg::OP_SLEEP) begin
      watchdog_counter_r <= exec_pkg::WDT_CLEAR; // RL2
      wdt_pre_r <= '0; // RL2
    end else begin
      wdt_pre_r <= wdt_pre_r + 1'b1;
      if (&wdt_pre_r) begin
        watchdog_counter_r <= watchdog_counter_r + 8'h01;
      end
    end
  end

  // port direction registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_a_r <= exec_pkg::DIR_RESET;
      dir_b_r <= exec_pkg::DIR_RESET;
      dir_c_r <= exec_pkg::DIR_RESET;
    end else if (exec_go && ins_op == exec_pkg::OP_DIR_LOAD) begin
      case (ins_arg)
        exec_pkg::DIR_SEL_A: begin
          dir_a_r <= w_r; // RL10
        end
        exec_pkg::DIR_SEL_B: begin
          dir_b_r <= w_r; // RL10
        end
        exec_pkg::DIR_SEL_C: begin
          dir_c_r <= w_r; // RL10
        end
        default: ;
      endcase
    end
  end

  // file register pointer for software access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      file_addr_r <= '0;
    end else if (sw_wr_faddr) begin
      file_addr_r <= wdata_r[FA_W-1:0];
    end
  end

  // file registers, no reset
  always_ff @(posedge aclk) begin
    if (exec_go && alu_writes && to_file) begin
      file_mem[f_idx] <= alu_res; // RL6 RL9
    end else if (sw_wr_fdata) begin
      file_mem[file_addr_r] <= wdata_r[7:0];
    end
  end

  // output registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_sleeping <= 1'b0;
      port_a_direction <= exec_pkg::DIR_RESET;
      port_b_direction <= exec_pkg::DIR_RESET;
      port_c_direction <= exec_pkg::DIR_RESET;
    end else begin
      core_sleeping <= sleep_r;
      port_a_direction <= dir_a_r;
      port_b_direction <= dir_b_r;
      port_c_direction <= dir_c_r;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

// ### logic/exec_pkg.sv
// constants, types and register map of the instruction execution block
// Overview of operation
// RL1 - sleep clears powerdown bit, sets timeout bit
// RL2 - sleep clears watchdog counter and prescaler
// RL3 - literal minus W into W, two's complement
// RL4 - carry/digit carry are not-borrow of subtraction
// RL5 - file minus W, updates C, DC, Z
// RL6 - destination bit 0 gives W, 1 file
// RL7 - W minus file minus borrow, to destination
// RL8 - swap file nibbles, no flags change
// RL9 - swap without destination writes back to file
// RL10 - W to direction register 5, 6, 7
// RL11 - W xor literal into W, zero only
// RL12 - W xor file to destination, zero only
// RL13 - zero flag set when result is zero
package exec_pkg;

  typedef enum logic [3:0] {
    OP_SLEEP = 4'h0,
    OP_SUB_LIT = 4'h1,
    OP_SUB_FILE = 4'h2,
    OP_SUB_BORROW = 4'h3,
    OP_SWAP = 4'h4,
    OP_DIR_LOAD = 4'h5,
    OP_XOR_LIT = 4'h6,
    OP_XOR_FILE = 4'h7
  } op_t;

  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_WREG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_DIR_A = 8'h0c;
  localparam logic [7:0] OFS_DIR_B = 8'h10;
  localparam logic [7:0] OFS_DIR_C = 8'h14;
  localparam logic [7:0] OFS_WDT = 8'h18;
  localparam logic [7:0] OFS_FILE_ADDR = 8'h1c;
  localparam logic [7:0] OFS_FILE_DATA = 8'h20;

  // instruction word fields
  localparam int unsigned INS_OP_LSB = 0;
  localparam int unsigned INS_DEST_BIT = 4;
  localparam int unsigned INS_DEST_GIVEN_BIT = 5;
  localparam int unsigned INS_ARG_LSB = 8;

  // status register fields
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_PD = 3;
  localparam int unsigned ST_TO = 4;
  localparam int unsigned ST_SLEEP = 5;

  localparam logic [7:0] DIR_SEL_A = 8'h05;
  localparam logic [7:0] DIR_SEL_B = 8'h06;
  localparam logic [7:0] DIR_SEL_C = 8'h07;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] WDT_CLEAR = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### logic/exec_alu.sv
// arithmetic and logic unit for the subtract, swap and xor instructions
`timescale 1ns/10ps
module exec_alu (
  input wire exec_pkg::op_t op,
  input wire logic [7:0] w_val,
  input wire logic [7:0] f_val,
  input wire logic [7:0] k_val,
  input wire logic c_in,
  output logic [7:0] result,
  output logic c_out,
  output logic dc_out,
  output logic z_out,
  output logic upd_cdc,
  output logic upd_z
);

  logic [7:0] sub_a;
  logic [7:0] sub_b;
  logic sub_cin;
  logic [8:0] sub_sum;
  logic [4:0] nib_sum;

  // a - b - borrow computed as a + ~b + carry
  always_comb begin
    sub_a = f_val;
    sub_b = w_val;
    sub_cin = 1'b1;
    case (op)
      exec_pkg::OP_SUB_LIT: begin
        sub_a = k_val; // RL3
      end
      exec_pkg::OP_SUB_BORROW: begin
        sub_a = w_val; // RL7
        sub_b = f_val;
        sub_cin = c_in;
      end
      default: begin
        sub_a = f_val; // RL5
      end
    endcase
    sub_sum = {1'b0, sub_a} + {1'b0, ~sub_b} + {8'h00, sub_cin};
    nib_sum = {1'b0, sub_a[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
  end

  always_comb begin
    result = f_val;
    upd_cdc = 1'b0;
    upd_z = 1'b0;
    case (op)
      exec_pkg::OP_SUB_LIT, exec_pkg::OP_SUB_FILE,
      exec_pkg::OP_SUB_BORROW: begin
        result = sub_sum[7:0];
        upd_cdc = 1'b1;
        upd_z = 1'b1;
      end
      exec_pkg::OP_SWAP: begin
        result = {f_val[3:0], f_val[7:4]}; // RL8
      end
      exec_pkg::OP_XOR_LIT: begin
        result = w_val ^ k_val; // RL11
        upd_z = 1'b1;
      end
      exec_pkg::OP_XOR_FILE: begin
        result = w_val ^ f_val; // RL12
        upd_z = 1'b1;
      end
      default: begin
        result = f_val;
      end
    endcase
    c_out = sub_sum[8]; // RL4
    dc_out = nib_sum[4]; // RL4
    z_out = (result == 8'h00); // RL13
  end

endmodule

// ### testbench/instr_exec_core_chk.sv
// bus timing and side-effect checks of the execution core
`timescale 1ns/10ps
module instr_exec_core_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port_a_direction,
  input wire logic [7:0] port_b_direction,
  input wire logic [7:0] port_c_direction,
  input wire logic core_sleeping
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence commit_seen;
    $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
  endsequence

  a_write_answer: assert property (both_taken |=>
    !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  a_write_unmapped: assert property ((both_taken and s_axi_awaddr > 8'h20)
    |=> ##1 s_axi_bresp == exec_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  a_bvalid_clear: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write response not retired");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h20 |=> s_axi_rresp == exec_pkg::RESP_SLVERR &&
    s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_rvalid_clear: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read not retired");
  a_dir_cause: assert property (
    !$stable({port_a_direction, port_b_direction, port_c_direction})
    |-> commit_seen) else $error("direction changed without a write");
  a_sleep_cause: assert property ($rose(core_sleeping) |->
    commit_seen and $past(s_axi_bresp) == exec_pkg::RESP_OKAY)
    else $error("halt without an accepted instruction");
endmodule

// ### testbench/subtract_xor_swap_sleep_exec_bench.sv
// self-checking bench of the execution core
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  num_errors++; $display("unexpected at %0t: %h vs %h", $time, a, b); \
  end end
module subtract_xor_swap_sleep_exec_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, core_sleeping;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] port_a_direction, port_b_direction, port_c_direction;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  logic [33:0] v;
  logic [7:0] ea = 8'hff, eb = 8'hff, ec = 8'hff;

  instr_exec_core i_dut (.*);

  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    `CHK(s_axi_bresp, er)
  endtask

  // returns response code above the read word
  task automatic rd(input logic [7:0] a, output logic [33:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = {s_axi_rresp, s_axi_rdata};
  endtask

  task automatic ex(input logic [3:0] op, input logic d, g,
                    input logic [7:0] arg);
    wr(exec_pkg::OFS_INSTR, {16'h0, arg, 2'b00, g, d, op},
       exec_pkg::RESP_OKAY);
  endtask

  // {digit carry, carry, result} of m - s - b
  function automatic logic [9:0] sb(input logic [7:0] m, s, input logic b);
    logic [8:0] t;
    logic [4:0] n;
    t = {1'b0, m} - {1'b0, s} - {8'h0, b};
    n = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, b};
    return {~n[4], ~t[8], t[7:0]};
  endfunction

  task automatic run_op(input exec_pkg::op_t op, input logic d, g,
                        input logic [7:0] w, f, k, input logic [2:0] st);
    logic [9:0] s;
    logic [2:0] es;
    logic tow;
    wr(exec_pkg::OFS_WREG, {24'h0, w}, exec_pkg::RESP_OKAY);
    wr(exec_pkg::OFS_FILE_ADDR, 32'h7f, exec_pkg::RESP_OKAY);
    wr(exec_pkg::OFS_FILE_DATA, {24'h0, f}, exec_pkg::RESP_OKAY);
    wr(exec_pkg::OFS_STATUS, {29'h0, st}, exec_pkg::RESP_OKAY);
    ex(op, d, g, (op == exec_pkg::OP_SUB_LIT ||
                  op == exec_pkg::OP_XOR_LIT) ? k : 8'h7f);
    es = st;
    tow = !d;
    case (op)
      exec_pkg::OP_SUB_LIT: begin
        s = sb(k, w, 1'b0);
        tow = 1'b1;
      end
      exec_pkg::OP_SUB_FILE: s = sb(f, w, 1'b0);
      exec_pkg::OP_SUB_BORROW: s = sb(w, f, !st[0]);
      exec_pkg::OP_SWAP: begin
        s = {es[1:0], f[3:0], f[7:4]};
        tow = g && !d;
      end
      exec_pkg::OP_XOR_LIT: begin
        s = {es[1:0], w ^ k};
        tow = 1'b1;
      end
      default: s = {es[1:0], w ^ f};
    endcase
    es[1:0] = s[9:8];
    if (op != exec_pkg::OP_SWAP) es[2] = (s[7:0] == 8'h00);
    rd(exec_pkg::OFS_WREG, v);
    `CHK(v[7:0], tow ? s[7:0] : w)
    rd(exec_pkg::OFS_FILE_DATA, v);
    `CHK(v[7:0], tow ? f : s[7:0])
    rd(exec_pkg::OFS_STATUS, v);
    `CHK(v[2:0], es)
  endtask

  task automatic t_reset();
    `CHK({port_a_direction, port_b_direction, port_c_direction}, 24'hffffff)
    `CHK(core_sleeping, 1'b0)
    rd(exec_pkg::OFS_STATUS, v);
    `CHK(v[4:0], 5'h18)
    wr(8'h40, 32'h1, exec_pkg::RESP_SLVERR);
    rd(8'h40, v);
    `CHK(v, {exec_pkg::RESP_SLVERR, 32'h0})
  endtask

  task automatic t_sub();
    run_op(exec_pkg::OP_SUB_LIT, 1'b0, 1'b0, 8'h10, 8'h00, 8'h10, 3'h0);
    run_op(exec_pkg::OP_SUB_LIT, 1'b0, 1'b0, 8'h06, 8'h00, 8'h05, 3'h7);
    run_op(exec_pkg::OP_SUB_LIT, 1'b0, 1'b0, 8'h01, 8'h00, 8'h20, 3'h0);
    run_op(exec_pkg::OP_SUB_FILE, 1'b0, 1'b0, 8'h01, 8'hff, 8'h00, 3'h4);
    run_op(exec_pkg::OP_SUB_FILE, 1'b1, 1'b0, 8'h0f, 8'hf0, 8'h00, 3'h0);
  endtask

  task automatic t_borrow();
    run_op(exec_pkg::OP_SUB_BORROW, 1'b0, 1'b0, 8'h30, 8'h10, 8'h00, 3'h0);
    run_op(exec_pkg::OP_SUB_BORROW, 1'b1, 1'b0, 8'h30, 8'h30, 8'h00, 3'h1);
    run_op(exec_pkg::OP_SUB_BORROW, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 3'h0);
  endtask

  task automatic t_swap();
    run_op(exec_pkg::OP_SWAP, 1'b0, 1'b0, 8'h11, 8'ha5, 8'h00, 3'h7);
    run_op(exec_pkg::OP_SWAP, 1'b0, 1'b1, 8'h22, 8'h3c, 8'h00, 3'h2);
    run_op(exec_pkg::OP_SWAP, 1'b1, 1'b1, 8'h33, 8'h0f, 8'h00, 3'h5);
  endtask

  task automatic t_xor();
    run_op(exec_pkg::OP_XOR_LIT, 1'b0, 1'b0, 8'h5a, 8'h00, 8'h5a, 3'h3);
    run_op(exec_pkg::OP_XOR_LIT, 1'b0, 1'b0, 8'hff, 8'h00, 8'h0f, 3'h4);
    run_op(exec_pkg::OP_XOR_FILE, 1'b1, 1'b0, 8'h0f, 8'hf0, 8'h00, 3'h4);
    run_op(exec_pkg::OP_XOR_FILE, 1'b0, 1'b0, 8'h33, 8'h33, 8'h00, 3'h0);
  endtask

  task automatic t_dir();
    wr(exec_pkg::OFS_STATUS, 32'h7, exec_pkg::RESP_OKAY);
    for (int s = 4; s < 8; s++) begin
      wr(exec_pkg::OFS_WREG, 32'(s * 3), exec_pkg::RESP_OKAY);
      ex(exec_pkg::OP_DIR_LOAD, 1'b0, 1'b0, 8'(s));
      if (s == 5) ea = 8'(s * 3);
      if (s == 6) eb = 8'(s * 3);
      if (s == 7) ec = 8'(s * 3);
      @(posedge aclk);
      `CHK({port_a_direction, port_b_direction, port_c_direction}, {ea, eb, ec})
    end
    rd(exec_pkg::OFS_STATUS, v);
    `CHK(v[2:0], 3'h7)
  endtask

  task automatic t_sleep();
    repeat (300) @(posedge aclk);
    rd(exec_pkg::OFS_WDT, v);
    `CHK(v[7:0] != 8'h00, 1'b1)
    wr(exec_pkg::OFS_STATUS, 32'h7, exec_pkg::RESP_OKAY);
    ex(exec_pkg::OP_SLEEP, 1'b0, 1'b0, 8'h00);
    rd(exec_pkg::OFS_STATUS, v);
    `CHK(v[5:0], 6'h37)
    rd(exec_pkg::OFS_WDT, v);
    `CHK(v[7:0], exec_pkg::WDT_CLEAR)
    `CHK(v[15:8] < 8'h10, 1'b1)
    `CHK(core_sleeping, 1'b1)
    wr(exec_pkg::OFS_INSTR, 32'hff06, exec_pkg::RESP_SLVERR);
    wr(exec_pkg::OFS_STATUS, 32'h0, exec_pkg::RESP_OKAY);
    @(posedge aclk);
    `CHK(core_sleeping, 1'b0)
    rd(exec_pkg::OFS_STATUS, v);
    `CHK(v[5:0], 6'h10)
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_sub();
    t_borrow();
    t_swap();
    t_xor();
    t_dir();
    t_sleep();
    give_verdict();
  end
endmodule
bind instr_exec_core instr_exec_core_chk i_chk (.*);
